// ===== rtl/sscl_pkg.sv
// Package of constants and types for the start/stop command logic
`default_nettype none
package sscl_pkg;
	// Stop method selection encodings
	localparam logic [13:0] STOP_COAST_MAX = 14'd100;
	localparam logic [13:0] STOP_DIR_MIN = 14'd1000;
	localparam logic [13:0] STOP_DIR_MAX = 14'd1100;
	localparam logic [13:0] STOP_DIR_RAMP = 14'd8888;
	localparam logic [13:0] STOP_DEFAULT = 14'd9999;
	localparam logic [13:0] STOP_DIR_OFFSET = 14'd1000;
	// Terminal function codes
	localparam logic [7:0] FUNC_ALT_SEL = 8'd3;
	localparam logic [7:0] FUNC_STOP_HOLD = 8'd25;
	localparam logic [7:0] FUNC_NONE = 8'hff;
	localparam int NUM_TERM = 3;
	// Value written to the extended display selection that unlocks writes
	localparam logic [13:0] EXT_DISP_OPEN = 14'd0;
	// Motor type code for permanent-magnet control
	localparam logic [1:0] MOTOR_PM = 2'd2;
	// Timing
	localparam int CLK_HZ = 100_000_000;
	localparam int SEC_CYCLES = CLK_HZ;
	// Pin filter
	localparam int SYNC_STAGES = 3;
	typedef enum logic [1:0] {
		SSCL_IDLE = 2'b00,
		SSCL_RUN = 2'b01,
		SSCL_DELAY = 2'b10,
		SSCL_COAST = 2'b11
	} sscl_state_t;
endpackage
`default_nettype wire

// ===== rtl/sscl_top.sv
// Start/stop command interpreter with stop method and second function select
// How it works
// - Alternate select switches parameter bank, and motor setting too except under magnet control
// - Permanent-magnet control keeps first motor setting
// - Alternate select taken from terminal coded 3
// - 0-100: fwd/rev start, coast after delay
// - 1000-1100: coast after setting minus 1000
// - 9999 or 8888: ramp down on stop
// - 1000-1100/8888: forward is run, reverse direction
// - Run low stops; run high, direction selects
// - Default: single input starts, both/neither ramp
// - Stop-hold high enables latching, inputs trigger only
// - Pulse high then low latches start
// - Stop-hold low clears latch, ramps down
// - Stop-hold taken from terminal coded 25
// - Jog makes stop-hold ignored
// - Output shutoff keeps latch
// - Forward/reverse start only via own selectors
// - Stop selection written only when display sel zero
`default_nettype none
module sscl_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic fwd_start_in,
	input wire logic rev_start_in,
	input wire logic [2:0] term_in,
	input wire logic [7:0] term_func_0,
	input wire logic [7:0] term_func_1,
	input wire logic [7:0] term_func_2,
	input wire logic [7:0] fwd_terminal_func_sel,
	input wire logic [7:0] rev_terminal_func_sel,
	input wire logic jog_in,
	input wire logic output_shutoff_in,
	input wire logic motor_type_pm,
	input wire logic [13:0] stop_method_wdata,
	input wire logic stop_method_we,
	input wire logic [13:0] ext_display_sel,
	output logic [13:0] stop_method_sel,
	output logic alt_param_select,
	output logic alt_motor_select,
	output logic run_cmd,
	output logic dir_rev,
	output logic ramp_stop_req,
	output logic coast_stop_req,
	output logic output_enable,
	output logic latched_start,
	output logic write_refused
);
	localparam logic [7:0] FWD_CODE = 8'd60;
	localparam logic [7:0] REV_CODE = 8'd61;

	// Three-stage pin filter for all contact inputs
	localparam int NPIN = 7;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] s1_r, s2_r, s3_r, flt_r;
	assign pin_raw = {output_shutoff_in, jog_in, term_in, rev_start_in, fwd_start_in};
	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			flt_r <= '0;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < NPIN; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					flt_r[i] <= s3_r[i];
				end
			end
		end
	end

	// Terminal function routing
	logic [7:0] func_code [sscl_pkg::NUM_TERM];
	logic [sscl_pkg::NUM_TERM-1:0] hit_alt, hit_hold, hit_any_hold;
	assign func_code[0] = term_func_0;
	assign func_code[1] = term_func_1;
	assign func_code[2] = term_func_2;
	genvar g;
	generate
		for (g = 0; g < sscl_pkg::NUM_TERM; g++) begin : g_term
			assign hit_alt[g] = flt_r[2+g] && (func_code[g] == sscl_pkg::FUNC_ALT_SEL);
			assign hit_hold[g] = flt_r[2+g] && (func_code[g] == sscl_pkg::FUNC_STOP_HOLD);
			assign hit_any_hold[g] = (func_code[g] == sscl_pkg::FUNC_STOP_HOLD);
		end
	endgenerate

	// Start inputs only count on their own dedicated selector code
	wire fwd_ok = (fwd_terminal_func_sel == FWD_CODE);
	wire rev_ok = (rev_terminal_func_sel == REV_CODE);
	wire fwd = flt_r[0] && fwd_ok;
	wire rev = flt_r[1] && rev_ok;
	wire jog = flt_r[5];
	wire shutoff = flt_r[6];
	wire alt_sel = |hit_alt;
	wire hold_assigned = |hit_any_hold;
	// Jog overrides the three-wire mode entirely
	wire three_wire = hold_assigned && !jog && (|hit_hold);
	wire hold_drop = hold_assigned && !jog && !(|hit_hold);

	// Stop method decode
	wire [13:0] sm = stop_method_sel;
	wire mode_coast_a = (sm <= sscl_pkg::STOP_COAST_MAX);
	wire mode_coast_b = (sm >= sscl_pkg::STOP_DIR_MIN) && (sm <= sscl_pkg::STOP_DIR_MAX);
	wire mode_dir = mode_coast_b || (sm == sscl_pkg::STOP_DIR_RAMP);
	wire mode_coast = mode_coast_a || mode_coast_b;
	wire [13:0] delay_sec = mode_coast_b ? 14'(sm - sscl_pkg::STOP_DIR_OFFSET) : sm;

	// Two-wire command decode
	logic tw_run, tw_rev;
	always_comb begin
		if (mode_dir) begin
			tw_run = fwd;
			tw_rev = rev;
		end else begin
			tw_run = fwd ^ rev;
			tw_rev = rev && !fwd;
		end
	end

	// Latched three-wire start: edge of trigger falling
	logic fwd_d_r, rev_d_r, latch_r, latch_rev_r;
	wire fwd_fall = fwd_d_r && !fwd;
	wire rev_fall = rev_d_r && !rev;
	logic latch_nxt, latch_rev_nxt;
	always_comb begin
		latch_nxt = latch_r;
		latch_rev_nxt = latch_rev_r;
		if (hold_drop) begin
			latch_nxt = 1'b0;
		end else if (three_wire) begin
			if (mode_dir) begin
				if (fwd_fall) begin
					latch_nxt = 1'b1;
					latch_rev_nxt = rev;
				end
			end else if (fwd_fall) begin
				latch_nxt = 1'b1;
				latch_rev_nxt = 1'b0;
			end else if (rev_fall) begin
				latch_nxt = 1'b1;
				latch_rev_nxt = 1'b1;
			end
		end else begin
			latch_nxt = 1'b0;
		end
		// Shutoff deliberately absent here so the latch survives it
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			fwd_d_r <= 1'b0;
			rev_d_r <= 1'b0;
			latch_r <= 1'b0;
			latch_rev_r <= 1'b0;
		end else begin
			fwd_d_r <= fwd;
			rev_d_r <= rev;
			latch_r <= latch_nxt;
			latch_rev_r <= latch_rev_nxt;
		end
	end

	wire want_run = three_wire ? latch_r : tw_run;
	wire want_rev = three_wire ? latch_rev_r : tw_rev;

	// Stop sequencing with seconds counter
	sscl_pkg::sscl_state_t st_r, st_nxt;
	logic [26:0] tick_r;
	logic [13:0] sec_r;
	wire sec_tick = (tick_r == 27'(sscl_pkg::SEC_CYCLES - 1));
	wire delay_done = (sec_r >= delay_sec);
	always_comb begin
		case (st_r)
			sscl_pkg::SSCL_IDLE: st_nxt = want_run ? sscl_pkg::SSCL_RUN : sscl_pkg::SSCL_IDLE;
			sscl_pkg::SSCL_RUN: begin
				if (want_run) begin
					st_nxt = sscl_pkg::SSCL_RUN;
				end else if (mode_coast) begin
					st_nxt = sscl_pkg::SSCL_DELAY;
				end else begin
					st_nxt = sscl_pkg::SSCL_IDLE;
				end
			end
			sscl_pkg::SSCL_DELAY: begin
				if (want_run) begin
					st_nxt = sscl_pkg::SSCL_RUN;
				end else if (delay_done) begin
					st_nxt = sscl_pkg::SSCL_COAST;
				end else begin
					st_nxt = sscl_pkg::SSCL_DELAY;
				end
			end
			sscl_pkg::SSCL_COAST: st_nxt = want_run ? sscl_pkg::SSCL_RUN : sscl_pkg::SSCL_COAST;
			default: st_nxt = sscl_pkg::SSCL_IDLE;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= sscl_pkg::SSCL_IDLE;
			tick_r <= '0;
			sec_r <= '0;
		end else begin
			st_r <= st_nxt;
			// Timer restarts when the start command drops
			if (st_r != sscl_pkg::SSCL_DELAY) begin
				tick_r <= '0;
				sec_r <= '0;
			end else if (sec_tick) begin
				tick_r <= '0;
				sec_r <= (sec_r == 14'h3fff) ? sec_r : sec_r + 14'h0001;
			end else begin
				tick_r <= tick_r + 27'h0000001;
			end
		end
	end

	// Stop method setting, write-guarded
	always_ff @(posedge mclk) begin
		if (rst) begin
			stop_method_sel <= sscl_pkg::STOP_DEFAULT;
			write_refused <= 1'b0;
		end else begin
			write_refused <= 1'b0;
			if (stop_method_we) begin
				if (ext_display_sel == sscl_pkg::EXT_DISP_OPEN) begin
					stop_method_sel <= stop_method_wdata;
				end else begin
					write_refused <= 1'b1;
				end
			end
		end
	end

	// Registered command outputs
	wire running = (st_nxt == sscl_pkg::SSCL_RUN);
	always_ff @(posedge mclk) begin
		if (rst) begin
			run_cmd <= 1'b0;
			dir_rev <= 1'b0;
			ramp_stop_req <= 1'b0;
			coast_stop_req <= 1'b0;
			output_enable <= 1'b0;
			latched_start <= 1'b0;
			alt_param_select <= 1'b0;
			alt_motor_select <= 1'b0;
		end else begin
			run_cmd <= running;
			if (running) begin
				dir_rev <= want_rev;
			end
			ramp_stop_req <= (st_nxt == sscl_pkg::SSCL_IDLE);
			coast_stop_req <= (st_nxt == sscl_pkg::SSCL_COAST) || shutoff;
			// Shutoff gates output enable and forces the coast request, never the command state
			output_enable <= running && !shutoff;
			latched_start <= latch_nxt;
			alt_param_select <= alt_sel;
			alt_motor_select <= alt_sel && !motor_type_pm;
		end
	end
endmodule
`default_nettype wire

// ===== dv/sscl_chk.sv
// Port assertions for the start/stop command logic
`default_nettype none
module sscl_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic fwd_start_in,
	input wire logic rev_start_in,
	input wire logic [2:0] term_in,
	input wire logic [7:0] term_func_0,
	input wire logic [7:0] term_func_1,
	input wire logic [7:0] term_func_2,
	input wire logic [7:0] fwd_terminal_func_sel,
	input wire logic [7:0] rev_terminal_func_sel,
	input wire logic jog_in,
	input wire logic output_shutoff_in,
	input wire logic motor_type_pm,
	input wire logic [13:0] stop_method_wdata,
	input wire logic stop_method_we,
	input wire logic [13:0] ext_display_sel,
	input wire logic [13:0] stop_method_sel,
	input wire logic alt_param_select,
	input wire logic alt_motor_select,
	input wire logic run_cmd,
	input wire logic dir_rev,
	input wire logic ramp_stop_req,
	input wire logic coast_stop_req,
	input wire logic output_enable,
	input wire logic latched_start,
	input wire logic write_refused
);
	// Eight-cycle windows cover the pin filter latency with margin
	wire no_hold = term_func_0 != 8'h19 && term_func_1 != 8'h19 && term_func_2 != 8'h19;
	wire sel_ok = fwd_terminal_func_sel == 8'h3c && rev_terminal_func_sel == 8'h3d;
	wire both_on = no_hold && sel_ok && !jog_in && fwd_start_in && rev_start_in;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_reset_default: assert property ($past(rst) |-> stop_method_sel == sscl_pkg::STOP_DEFAULT
		&& !run_cmd) else $error("stop selection not default after reset");
	a_write_taken: assert property (stop_method_we && ext_display_sel == 14'h0 |=>
		stop_method_sel == $past(stop_method_wdata) && !write_refused)
		else $error("open write not taken");
	a_write_blocked: assert property (stop_method_we && ext_display_sel != 14'h0 |=>
		write_refused && $stable(stop_method_sel)) else $error("locked write not refused");
	a_pm_first: assert property (motor_type_pm && $past(motor_type_pm) |-> !alt_motor_select)
		else $error("alternate motor used under magnet control");
	a_alt_bank: assert property ((term_func_1 == 8'h03 && term_in[1])[*8] |-> alt_param_select)
		else $error("second bank not selected");
	a_both_ramp: assert property ((both_on && stop_method_sel == sscl_pkg::STOP_DEFAULT)[*8]
		|-> !run_cmd && ramp_stop_req) else $error("both inputs did not stop");
	a_dir_select: assert property ((both_on && stop_method_sel == sscl_pkg::STOP_DIR_RAMP)[*8]
		|-> run_cmd && dir_rev) else $error("direction input ignored");
	a_shutoff_coast: assert property (output_shutoff_in[*6] |-> ##[0:4]
		(coast_stop_req && !output_enable)) else $error("shutoff did not stop output");
	a_hold_clear: assert property ((term_func_0 == 8'h19 && !term_in[0] && !jog_in)[*8]
		|-> !latched_start) else $error("latch kept with hold low");
	c_refused: cover property (write_refused);
	c_latched_rev: cover property (latched_start && dir_rev);
	c_shut_latched: cover property (coast_stop_req && latched_start);
endmodule
bind sscl_top sscl_chk sscl_chk_inst (.*);
`default_nettype wire

// ===== dv/sscl_contacts.sv
// Model of the external start, direction, hold and shutoff contacts
`default_nettype none
module sscl_contacts (
	input wire logic mclk,
	input wire logic [6:0] want,
	output logic [6:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// Contacts move away from the sampling edge and then stay put
	initial pins = 7'h00;
	always @(negedge mclk) pins <= want;
endmodule
`default_nettype wire

// ===== dv/tb_start_stop_command_logic.sv
// Testbench for the start/stop command logic
`default_nettype none
module tb_start_stop_command_logic;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, rst = 1, pm = 0, we = 0;
	logic [6:0] want = 7'h00, pins;
	logic [7:0] tf0 = 8'hff, st;
	logic [13:0] wd = 14'h0, ext = 14'h0, sel_exp = 14'h270f, sel;
	logic [21:0] q[$];
	logic [31:0] seed = 32'h34;
	logic [7:0] tab[4] = '{8'hc8, 8'h60, 8'h88, 8'h20};
	logic [13:0] cs[2] = '{14'h0, 14'h3e8};
	int fail_count = 0, checked = 0;
	event seen;
	always #5 mclk = ~mclk;
	sscl_contacts sscl_contacts_inst (.mclk(mclk), .want(want), .pins(pins));
	sscl_top sscl_top_inst (.mclk(mclk), .rst(rst), .fwd_start_in(pins[0]),
		.rev_start_in(pins[1]), .term_in(pins[4:2]), .term_func_0(tf0), .term_func_1(8'h03),
		.term_func_2(8'hff), .fwd_terminal_func_sel(8'h3c), .rev_terminal_func_sel(8'h3d),
		.jog_in(pins[5]), .output_shutoff_in(pins[6]), .motor_type_pm(pm),
		.stop_method_wdata(wd), .stop_method_we(we), .ext_display_sel(ext),
		.stop_method_sel(sel), .alt_param_select(st[1]), .alt_motor_select(st[0]),
		.run_cmd(st[7]), .dir_rev(st[6]), .ramp_stop_req(st[5]), .coast_stop_req(st[4]),
		.output_enable(st[3]), .latched_start(st[2]), .write_refused());
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [21:0] got, input logic [21:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Wait past the pin filter, then give a bounded settle window
	task automatic expect_st(input logic [7:0] e);
		int n;
		n = 0;
		repeat (8) @(negedge mclk);
		while ({sel, st} !== {sel_exp, e} && n < 40) begin
			@(negedge mclk);
			n++;
		end
		q.push_back({sel_exp, e});
		-> seen;
		#1;
		if (n == 40) give_verdict();
	endtask
	always @(seen) check({sel, st}, q.pop_front());
	task automatic put(input logic [6:0] w, input logic [7:0] e);
		@(negedge mclk);
		want = w;
		expect_st(e);
	endtask
	task automatic pulse(input logic [6:0] w);
		@(negedge mclk);
		want = w;
		repeat (8) @(negedge mclk);
	endtask
	task automatic wr(input logic [13:0] d, input logic [13:0] x);
		@(negedge mclk);
		wd = d;
		ext = x;
		we = 1;
		@(negedge mclk);
		we = 0;
		if (x == 14'h0) sel_exp = d;
	endtask
	initial begin
		repeat (20) @(negedge mclk);
		rst = 0;
		for (int i = 0; i < 4; i++) put(7'(i < 2 ? i + 2 : 3 - i), tab[i]);
		$display("two-wire test done");
		wr(14'h22b8, 14'h0);
		for (int i = 0; i < 4; i++) put(7'(3 - i), tab[i]);
		$display("run and direction test done");
		foreach (cs[j]) begin
			wr(cs[j], 14'h0);
			put(7'h01, 8'h88);
			put(7'h00, 8'h10);
		end
		$display("coast test done");
		repeat (4) begin
			seed = xs(seed);
			wr(seed[13:0], seed[27:14] | 14'h1);
			expect_st(8'h10);
		end
		wr(14'h270f, 14'h0);
		$display("write lock test done");
		tf0 = 8'h19;
		pulse(7'h05);
		put(7'h04, 8'h8c);
		pulse(7'h06);
		put(7'h04, 8'hcc);
		put(7'h44, 8'hd4);
		put(7'h04, 8'hcc);
		put(7'h00, 8'h60);
		$display("three-wire test done");
		put(7'h21, 8'h88);
		put(7'h00, 8'h20);
		$display("jog test done");
		put(7'h08, 8'h23);
		pm = 1;
		expect_st(8'h22);
		wr(14'h22b8, 14'h0);
		rst = 1;
		repeat (3) @(negedge mclk);
		rst = 0;
		sel_exp = 14'h270f;
		expect_st(8'h22);
		$display("bank and reset test done");
		give_verdict();
	end
endmodule
`default_nettype wire
